// file: design/csrg_pkg.sv
// Package: constants and types for the clock select and reset generator
package csrg_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS          = 72;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES      = (CLK_HZ / 1000) * POWER_UP_DELAY_TIMER_MS;
  localparam int unsigned XTAL_START_EDGES = 1024;
  localparam int unsigned MASTER_CLEAR_INPUT_FILT_CYCLES = 4;
  localparam int unsigned ROM_LAST_ADDR    = 32'h0000_03ff;
  // ---------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TRIM   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAUSE  = 8'h0c;
  // Config register fields
  localparam int CFG_FOSC_LSB  = 0;
  localparam int CFG_PWRTD_BIT = 4;
  localparam int CFG_RESET_PIN_SELECT_BIT = 5;
  localparam int CFG_BODEN_BIT = 6;
  localparam logic [6:0] CFG_RESET = 7'h7f;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  // Status register fields
  localparam int ST_PD_BIT  = 0;
  localparam int ST_TO_BIT  = 1;
  localparam int ST_BOD_BIT = 2;
  localparam int ST_POR_BIT = 3;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FOSC_LP_XTAL = 3'h0, FOSC_XTAL = 3'h1, FOSC_HS_XTAL = 3'h2, FOSC_EXT = 3'h3,
    FOSC_INT_IO = 3'h4, FOSC_INT_CLK = 3'h5, FOSC_RC_IO = 3'h6, FOSC_RC_CLK = 3'h7
  } csrg_fosc_t;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_WDT_RUN, CAUSE_WDT_SLEEP,
    CAUSE_MASTER_CLEAR_INPUT_RUN, CAUSE_MASTER_CLEAR_INPUT_SLEEP, CAUSE_BOD
  } csrg_cause_t;
endpackage

// file: design/csrg_div_if.sv
// Interface: divided clock request and output between top and divider
`timescale 1ns/1ps
`default_nettype none
interface csrg_div_if;
  logic enable;
  logic clk_out;
  modport ctrl (output enable, input clk_out);
  modport div  (input enable, output clk_out);
endinterface
`default_nettype wire

// file: design/csrg_div4.sv
// Divide-by-four generator for the divided clock output
`timescale 1ns/1ps
`default_nettype none
module csrg_div4
  import csrg_pkg::*;
(
  input  wire logic  CORE_CLK_I,
  input  wire logic  RST_I,
  input  wire logic  osc_tick_i,
  csrg_div_if.div    div
);
  logic [1:0] cnt_q;
  logic       out_q;
  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !div.enable) begin
      cnt_q <= 2'h0;
    end else if (osc_tick_i) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Half period is two oscillator ticks
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !div.enable) begin
      out_q <= 1'b0;
    end else if (osc_tick_i && cnt_q[0]) begin
      out_q <= ~out_q;
    end
  end
  assign div.clk_out = out_q;
endmodule
`default_nettype wire

// file: design/csrg_top.sv
// Top: clock source select, reset cause tracking and reset sequencing
// Function
// - Crystal modes also accept an external clock driven onto the oscillator input.
// - RC and internal modes each have pin-four I/O and clock-out variants.
// - Clock-out variant drives pin four with oscillator frequency over four.
// - Clock output only in internal and RC modes.
// - Trimmed internal oscillator gives nominal 4 MHz system clock.
// - Trim held at last program word; software writes it into trim register.
// - Six reset causes are distinguished.
// - Config and trim registers are untouched by every reset but power-on (RST_I).
// - Other registers reset on power-on, master-clear, watchdog and brown-out.
// - Watchdog wake-up from sleep resets no registers.
// - Time-out and power-down flags set per reset kind.
// - Master-clear path filters out short pulses.
// - Watchdog reset never pulls the master-clear pin low.
// - Internal master-clear option ties reset input inactive; no pull-up.
// - Power-on detect holds reset until supply is adequate.
// - Power-on detect does not reset on falling supply.
// - Power-up delay of 72 ms, only after power-on or brown-out.
// - Device held in reset while power-up delay counts.
// - Power-up delay disabled when its bit is 1, enabled at 0.
// - Oscillator select field decodes into eight modes.
// - Reset pin select 1 gives master-clear, 0 gives digital I/O.
// - Crystal modes wait 1024 oscillator cycles after power-on or wake.
// - Sequence: power-on detect, power-up delay, crystal start-up count.
`timescale 1ns/1ps
`default_nettype none
module csrg_top
  import csrg_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // Power and reset events
  input  wire logic        SUPPLY_OK_I,
  input  wire logic        BROWNOUT_I,
  input  wire logic        WDT_TIMEOUT_I,
  input  wire logic        SLEEPING_I,
  input  wire logic        MASTER_CLEAR_INPUT_N_I,
  // Oscillator input pin edge tick and pin-four drive
  input  wire logic        OSC_INPUT_TICK_I,
  input  wire logic        PIN_FOUR_IO_DATA_I,
  input  wire logic        PIN_FOUR_IO_OE_I,
  output logic             PIN_FOUR_O,
  output logic             PIN_FOUR_OE_O,
  output logic             MASTER_CLEAR_PIN_OE_O,
  output logic             SYS_RESET_O,
  output logic             WDT_WAKE_O,
  output logic [2:0]       CLOCK_SOURCE_O
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_xtal(input logic [2:0] f);
    is_xtal = (f == FOSC_LP_XTAL) || (f == FOSC_XTAL) || (f == FOSC_HS_XTAL);
  endfunction
  function automatic logic has_divided_clock_output(input logic [2:0] f);
    has_divided_clock_output = (f == FOSC_INT_CLK) || (f == FOSC_RC_CLK);
  endfunction

  typedef enum {SEQ_POR, SEQ_POWER_UP_DELAY_TIMER, SEQ_OST, SEQ_RUN} csrg_seq_t;

  logic [6:0]  cfg_q;
  logic [7:0]  trim_q;
  logic        to_q, pd_q, bod_n_q, por_n_q;
  csrg_cause_t cause_q;
  csrg_seq_t   seq_q;
  logic [31:0] cnt_q;
  logic [10:0] ost_q;
  logic [1:0]  filt_q;
  logic [2:0]  flt_cnt_q;
  logic        master_clear_input_q;
  logic        hold_q;
  logic        rst_sync_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        brown_q;
  logic        supply_q;
  logic        wake_q;
  logic        ost_wake_q;
  logic [2:0]  fosc;
  logic        master_clear_input_req;
  logic        wb_req;
  csrg_div_if  div_bus ();

  assign fosc   = cfg_q[CFG_FOSC_LSB +: 3];
  assign wb_req = CYC_I && STB_I && !ack_q;

  // ---------------------------------------------------------------
  // Master-clear filter
  // ---------------------------------------------------------------
  // Pin drops only when low for several cycles; glitches are ignored
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      filt_q    <= 2'h3;
      flt_cnt_q <= 3'h0;
      master_clear_input_q    <= 1'b0;
    end else begin
      filt_q <= {filt_q[0], MASTER_CLEAR_INPUT_N_I};
      if (!cfg_q[CFG_RESET_PIN_SELECT_BIT]) begin
        flt_cnt_q <= 3'h0;
        master_clear_input_q    <= 1'b0;
      end else if (!filt_q[1]) begin
        if (flt_cnt_q == 3'(MASTER_CLEAR_INPUT_FILT_CYCLES)) begin
          master_clear_input_q <= 1'b1;
        end else begin
          flt_cnt_q <= flt_cnt_q + 3'h1;
        end
      end else begin
        flt_cnt_q <= 3'h0;
        master_clear_input_q    <= 1'b0;
      end
    end
  end
  assign master_clear_input_req = master_clear_input_q;
  // Pin is input only: watchdog never drives it
  assign MASTER_CLEAR_PIN_OE_O = 1'b0;

  // ---------------------------------------------------------------
  // Supply and brown-out sampling
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      supply_q <= 1'b0;
      brown_q  <= 1'b0;
    end else begin
      supply_q <= SUPPLY_OK_I;
      brown_q  <= BROWNOUT_I && cfg_q[CFG_BODEN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Time-out sequencer
  // ---------------------------------------------------------------
  // RST_I models the power-on event itself
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      seq_q <= SEQ_POR;
      cnt_q <= 32'h0;
      ost_q <= 11'h0;
    end else begin
      case (seq_q)
        SEQ_POR: begin
          cnt_q <= 32'h0;
          ost_q <= 11'h0;
          if (supply_q && !brown_q) begin
            seq_q <= cfg_q[CFG_PWRTD_BIT] ? SEQ_OST : SEQ_POWER_UP_DELAY_TIMER;
          end
        end
        SEQ_POWER_UP_DELAY_TIMER: begin
          if (brown_q) begin
            seq_q <= SEQ_POR;
          end else if (cnt_q == POWER_UP_DELAY_TIMER_CYC - 1) begin
            seq_q <= SEQ_OST;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SEQ_OST: begin
          if (brown_q) begin
            seq_q <= SEQ_POR;
          end else if (!is_xtal(fosc) || ost_q == 11'(XTAL_START_EDGES)) begin
            seq_q <= SEQ_RUN;
          end else if (OSC_INPUT_TICK_I) begin
            ost_q <= ost_q + 11'h1;
          end
        end
        SEQ_RUN: begin
          // Falling supply alone does not restart; only brown-out does
          if (brown_q) begin
            seq_q <= SEQ_POR;
          end else if (wake_q) begin
            ost_q <= 11'h0;
            seq_q <= SEQ_OST;
          end
        end
        default: seq_q <= SEQ_POR;
      endcase
    end
  end

  // Watchdog in sleep is a wake, not a reset
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= WDT_TIMEOUT_I && SLEEPING_I && seq_q == SEQ_RUN;
    end
  end
  assign WDT_WAKE_O = wake_q;

  // ---------------------------------------------------------------
  // Wake-up start-up tracking
  // ---------------------------------------------------------------
  // Wake pulse lasts one cycle, so the start-up run it opens is remembered
  // Limitation: registers are kept, but no core stall is modelled meanwhile
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ost_wake_q <= 1'b0;
    end else if (seq_q == SEQ_RUN && wake_q) begin
      ost_wake_q <= 1'b1;
    end else if (seq_q != SEQ_OST) begin
      ost_wake_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Internal reset
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= (seq_q != SEQ_RUN && !(seq_q == SEQ_OST && ost_wake_q)) || master_clear_input_req
                || (WDT_TIMEOUT_I && !SLEEPING_I);
    end
  end
  // Release lands on one clock edge for all logic
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rst_sync_q <= 1'b1;
    end else begin
      rst_sync_q <= hold_q;
    end
  end
  assign SYS_RESET_O = rst_sync_q;

  // ---------------------------------------------------------------
  // Reset cause and status flags
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cause_q <= CAUSE_POR;
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
      por_n_q <= 1'b0;
      bod_n_q <= 1'b1;
    end else begin
      if (brown_q && seq_q != SEQ_POR) begin
        cause_q <= CAUSE_BOD;
        to_q    <= 1'b1;
        pd_q    <= 1'b1;
        bod_n_q <= 1'b0;
      end else if (WDT_TIMEOUT_I && seq_q == SEQ_RUN) begin
        cause_q <= SLEEPING_I ? CAUSE_WDT_SLEEP : CAUSE_WDT_RUN;
        to_q    <= 1'b0;
        if (SLEEPING_I) begin
          pd_q <= 1'b0;
        end
      end else if (master_clear_input_req && !hold_q) begin
        cause_q <= SLEEPING_I ? CAUSE_MASTER_CLEAR_INPUT_SLEEP : CAUSE_MASTER_CLEAR_INPUT_RUN;
        if (SLEEPING_I) begin
          to_q <= 1'b1;
          pd_q <= 1'b0;
        end
      end else if (wb_req && WE_I && ADR_I == ADDR_STATUS && SEL_I[0]) begin
        por_n_q <= DAT_I[ST_POR_BIT];
        bod_n_q <= DAT_I[ST_BOD_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Config and trim registers
  // ---------------------------------------------------------------
  // Trim is untouched by internal resets; only RST_I restores it
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cfg_q  <= CFG_RESET;
      trim_q <= TRIM_RESET;
    end else if (wb_req && WE_I && SEL_I[0]) begin
      if (ADR_I == ADDR_CONFIG) begin
        cfg_q <= DAT_I[6:0];
      end
      if (ADR_I == ADDR_TRIM) begin
        trim_q <= DAT_I[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Wishbone read and ack
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !WE_I) begin
        case (ADR_I)
          ADDR_CONFIG: dat_q <= {25'h0, cfg_q};
          ADDR_TRIM:   dat_q <= {24'h0, trim_q};
          ADDR_STATUS: dat_q <= {28'h0, por_n_q, bod_n_q, to_q, pd_q};
          ADDR_CAUSE:  dat_q <= {29'h0, cause_q};
          default:     dat_q <= 32'h0;
        endcase
      end
    end
  end
  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // ---------------------------------------------------------------
  // Clock source and pin four
  // ---------------------------------------------------------------
  // Reference clock of the transmitter is not a selectable source
  assign CLOCK_SOURCE_O   = fosc;
  assign div_bus.enable   = has_divided_clock_output(fosc) && !rst_sync_q;
  csrg_div4 u_div (
    .CORE_CLK_I (CORE_CLK_I),
    .RST_I      (RST_I),
    .osc_tick_i (OSC_INPUT_TICK_I),
    .div        (div_bus.div)
  );
  always_comb begin
    if (has_divided_clock_output(fosc)) begin
      PIN_FOUR_O    = div_bus.clk_out;
      PIN_FOUR_OE_O = 1'b1;
    end else if (fosc == FOSC_INT_IO || fosc == FOSC_RC_IO || fosc == FOSC_EXT) begin
      PIN_FOUR_O    = PIN_FOUR_IO_DATA_I;
      PIN_FOUR_OE_O = PIN_FOUR_IO_OE_I;
    end else begin
      PIN_FOUR_O    = 1'b0;
      PIN_FOUR_OE_O = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/csrg_asserts.sv
// Checker: bus handshake, pin-four and reset event properties of the top
`timescale 1ns/1ps
`default_nettype none
module csrg_asserts (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_I,
  input wire logic       CYC_I,
  input wire logic       STB_I,
  input wire logic       ACK_O,
  input wire logic       SUPPLY_OK_I,
  input wire logic       BROWNOUT_I,
  input wire logic       WDT_TIMEOUT_I,
  input wire logic       SLEEPING_I,
  input wire logic       MASTER_CLEAR_INPUT_N_I,
  input wire logic       PIN_FOUR_IO_DATA_I,
  input wire logic       PIN_FOUR_IO_OE_I,
  input wire logic       PIN_FOUR_O,
  input wire logic       PIN_FOUR_OE_O,
  input wire logic       MASTER_CLEAR_PIN_OE_O,
  input wire logic       SYS_RESET_O,
  input wire logic       WDT_WAKE_O,
  input wire logic [2:0] CLOCK_SOURCE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire calm = SUPPLY_OK_I && !BROWNOUT_I && !WDT_TIMEOUT_I;
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence req_s;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence glitch_s;
    $fell(MASTER_CLEAR_INPUT_N_I) && calm && !SYS_RESET_O
    ##1 (calm && !MASTER_CLEAR_INPUT_N_I) [*2] ##1 (calm && MASTER_CLEAR_INPUT_N_I);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ack_follows: assert property (req_s |=> ACK_O) else $error("ack late");
  a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_ack_idle: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack unasked");
  a_glitch_ignored: assert property (glitch_s |-> !SYS_RESET_O [*4])
    else $error("short reset pulse taken");
  a_pin_not_pulled: assert property (!MASTER_CLEAR_PIN_OE_O)
    else $error("reset pin driven");
  a_io_variant: assert property (!SYS_RESET_O && CLOCK_SOURCE_O inside {3'h4, 3'h6}
    |-> PIN_FOUR_O == PIN_FOUR_IO_DATA_I && PIN_FOUR_OE_O == PIN_FOUR_IO_OE_I)
    else $error("pin four not io");
  a_divided_clock_output_drive: assert property (!SYS_RESET_O && CLOCK_SOURCE_O inside {3'h5, 3'h7}
    |-> PIN_FOUR_OE_O) else $error("clock out not driven");
  a_por_hold: assert property (SYS_RESET_O && !SUPPLY_OK_I |=> SYS_RESET_O)
    else $error("reset left with low supply");
  a_no_fall_rst: assert property ($fell(SUPPLY_OK_I) && !SYS_RESET_O && !BROWNOUT_I
    && !WDT_TIMEOUT_I && MASTER_CLEAR_INPUT_N_I |=> !SYS_RESET_O)
    else $error("reset on falling supply");
  a_wdt_run_rst: assert property ($rose(WDT_TIMEOUT_I) && !SLEEPING_I && !SYS_RESET_O
    |-> ##[1:3] SYS_RESET_O) else $error("watchdog reset missing");
  a_wdt_wake: assert property ($rose(WDT_TIMEOUT_I) && SLEEPING_I && !SYS_RESET_O
    |-> ##[0:3] WDT_WAKE_O) else $error("watchdog wake missing");
  a_wake_pulse: assert property (WDT_WAKE_O |=> !WDT_WAKE_O) else $error("wake too long");
endmodule
`default_nettype wire

// file: tb/csrg_ext_model.sv
// Model of the external clock source and reset circuit
`timescale 1ns/1ps
`default_nettype none
module csrg_ext_model (
  input  wire logic clk_i,
  output var  logic tick_o   = 1'b0,
  output var  logic master_clear_input_n_o = 1'b1
);
  logic [1:0] div_q = 2'h0;
  // External clock on the oscillator input, one tick every third cycle
  // Transmitter reference clock is never offered here as system clock
  always @(posedge clk_i) begin
    div_q  <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    tick_o <= (div_q == 2'h2);
  end
  // Pin always driven: no internal pull-up to fall back on
  task automatic hold_low(input int n);
    @(posedge clk_i) master_clear_input_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    master_clear_input_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Testbench: bus, pin-four and reset sequencing scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csrg_pkg::*;
  localparam int unsigned PW = 40;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, tick, master_clear_input_n;
  logic sup = 0, bo = 0, wdt = 0, slp = 0, io_d = 0, io_oe = 0;
  logic p4, p4oe, mpoe, srst, wake;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [2:0]  src;
  int err_count = 0, num_checks = 0, wakes = 0;
  int cz[5] = '{6, 4, 5, 2, 3};
  logic [7:0] sm[5] = '{8'hfb, 8'h33, 8'h32, 8'h30, 8'h30};
  initial forever #25 clk = ~clk;
  csrg_top #(.POWER_UP_DELAY_TIMER_CYC(PW)) DUT (.CORE_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .SUPPLY_OK_I(sup), .BROWNOUT_I(bo), .WDT_TIMEOUT_I(wdt), .SLEEPING_I(slp),
    .MASTER_CLEAR_INPUT_N_I(master_clear_input_n), .OSC_INPUT_TICK_I(tick), .PIN_FOUR_IO_DATA_I(io_d),
    .PIN_FOUR_IO_OE_I(io_oe), .PIN_FOUR_O(p4), .PIN_FOUR_OE_O(p4oe),
    .MASTER_CLEAR_PIN_OE_O(mpoe), .SYS_RESET_O(srst), .WDT_WAKE_O(wake), .CLOCK_SOURCE_O(src));
  csrg_ext_model ext (.clk_i(clk), .tick_o(tick), .master_clear_input_n_o(master_clear_input_n));
  // Wake pulses seen over the whole run
  always @(posedge clk) wakes <= wakes + int'(wake === 1'b1);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  // Cycles of internal reset, counted until release
  task automatic measure(output int hi);
    int n;
    n = 0; hi = 0;
    while (srst !== 1'b1 && n < 40) begin @(posedge clk); n++; end
    while (srst === 1'b1 && hi < 20000) begin @(posedge clk); hi++; end
  endtask
  task automatic quiet(output int c);
    c = 0;
    repeat (12) begin @(posedge clk); c += (srst !== 1'b0); end
  endtask
  // Events: 0 brown-out, 1 clear run, 2 clear sleep, 3 watchdog run, 4 watchdog sleep
  task automatic fire(input int k);
    slp <= (k == 2 || k == 4);
    if (k == 0) begin bo <= 1; repeat (3) @(posedge clk); bo <= 0; end
    else if (k >= 3) begin @(posedge clk); wdt <= 1; @(posedge clk); wdt <= 0; end
    else ext.hold_low(10);
  endtask
  function automatic int hold_len(input int f, input bit pw);
    return (pw ? PW : 0) + (f < 3 ? 3 * XTAL_START_EDGES : 0);
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int hi, i, k, tg;
    logic pv;
    logic [31:0] t;
    void'($urandom(60662));
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (5) @(posedge clk);
    check(srst, 1'b1);
    check(mpoe, 1'b0);
    sup <= 1;
    measure(hi);
    check(hi <= 15, 1);
    rc(ADDR_CONFIG, 32'hffffffff, 32'h7f);
    rc(ADDR_TRIM, 32'hffffffff, 32'h80);
    rc(ADDR_CAUSE, 32'h7, 32'h1);
    rc(ADDR_STATUS, 32'hb, 32'h3);
    rc(8'h10, 32'hffffffff, 32'h0);
    t = $urandom & 32'hff;
    wr(ADDR_TRIM, t);
    rc(ADDR_TRIM, 32'hff, t);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CONFIG, 32'h70 | i);
      io_d <= 1'($urandom);
      io_oe <= 1'($urandom);
      @(posedge clk); pv = p4; tg = 0;
      repeat (24) begin @(posedge clk); tg += (p4 !== pv); pv = p4; end
      check(src, i);
      check(tg, (i == 5 || i == 7) ? 4 : 0);
      if (i inside {3, 4, 6}) check({p4, p4oe}, {io_d, io_oe});
    end
    wr(ADDR_CONFIG, 32'h66);
    wr(ADDR_STATUS, 32'h0c);
    for (k = 0; k < 5; k++) begin
      fire(k);
      if (k < 4) measure(hi);
      else quiet(hi);
      slp <= 0;
      if (k < 4) check(hi >= hold_len(6, k == 0) && hi <= hold_len(6, k == 0) + 15, 1);
      else check(hi, 0);
      rc(ADDR_CAUSE, 32'h7, cz[k]);
      rc(ADDR_STATUS, sm[k][7:4], sm[k][3:0]);
    end
    check(wakes, 1);
    rc(ADDR_TRIM, 32'hff, t);
    ext.hold_low(3);
    quiet(hi);
    check(hi, 0);
    wr(ADDR_CONFIG, 32'h46);
    ext.hold_low(10);
    quiet(hi);
    check(hi, 0);
    sup <= 0;
    @(posedge clk) sup <= 1;
    quiet(hi);
    check(hi, 0);
    wr(ADDR_CONFIG, 32'h61);
    fire(0);
    measure(hi);
    check(hi >= hold_len(1, 1) && hi <= hold_len(1, 1) + 15, 1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
bind csrg_top csrg_asserts u_chk (.CORE_CLK_I, .RST_I, .CYC_I, .STB_I, .ACK_O, .SUPPLY_OK_I,
  .BROWNOUT_I, .WDT_TIMEOUT_I, .SLEEPING_I, .MASTER_CLEAR_INPUT_N_I, .PIN_FOUR_IO_DATA_I,
  .PIN_FOUR_IO_OE_I, .PIN_FOUR_O, .PIN_FOUR_OE_O, .MASTER_CLEAR_PIN_OE_O, .SYS_RESET_O,
  .WDT_WAKE_O, .CLOCK_SOURCE_O);
`default_nettype wire
